// *** rtl/clm_consts.svh ***
/*
 * constants of the load / multiply / or execution unit: opcodes,
 * cycle counts, flag bit positions and software register map.
 * assumes: included by bare name from the unit.
 */
`ifndef CLM_CONSTS_SVH
`define CLM_CONSTS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define CLM_OP_LDI        8'hf3
`define CLM_OP_WORD_PAIR  8'hc4
`define CLM_OP_WORD_IND   8'hc5
`define CLM_OP_WORD_IMM   8'hc6
`define CLM_OP_MUL_R      8'h84
`define CLM_OP_MUL_IND    8'h85
`define CLM_OP_MUL_IMM    8'h86
`define CLM_OP_NEXT       8'h0f
`define CLM_OP_NOP        8'hff
`define CLM_OP_OR_WW      8'h42
`define CLM_OP_OR_WI      8'h43
`define CLM_OP_OR_GG      8'h44
`define CLM_OP_OR_GI      8'h45
`define CLM_OP_OR_IMM     8'h46

// ----------------------------------------
// cycles per instruction, start edge to done edge
// ----------------------------------------
`define CLM_CYC_LDI    5'h0e
`define CLM_CYC_WORD   5'h08
`define CLM_CYC_MUL    5'h16
`define CLM_CYC_NEXT   5'h0a
`define CLM_CYC_NOP    5'h04
`define CLM_CYC_OR_WW  5'h04
`define CLM_CYC_OR     5'h06

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define CLM_FLG_C      3'h7
`define CLM_FLG_Z      3'h6
`define CLM_FLG_S      3'h5
`define CLM_FLG_V      3'h4

// ----------------------------------------
// software registers
// ----------------------------------------
`define CLM_SW_CTRL    2'h0
`define CLM_SW_STATUS  2'h1
`define CLM_SW_LASTOP  2'h2
`define CLM_CTRL_HALT  3'h0
`define CLM_ST_BUSY    3'h0
`define CLM_ST_ILL     3'h1
`define CLM_IP_STEP    16'h0002

`endif

// *** rtl/clm_exec.sv ***
/*
 * execution unit for pre-increment store, word load, unsigned multiply,
 * threaded next, no-operation and logical or.
 * assumes: one clock; register file and memories answer reads
 * combinationally from the registered address in the same cycle and
 * take writes at the next edge; start comes from logic on clk_sys.
 */
// Operation
// - pre-increment pair address then transfer, 14 cycles
// - copy working register to addressed memory byte
// - even pair program memory, odd data memory
// - full 16-bit address over 64 Kbyte
// - word load in 8 cycles, three source forms
// - high byte to lower register, low next
// - 8x8 unsigned product into pair, 22 cycles
// - multiply sets C Z S, clears V
// - next loads pc from ip word, ip+2
// - no-operation changes nothing, 4 cycles
// - or stores src or dst into dst
// - or sets Z S, clears V, keeps C
// - load, next, nop leave flags untouched
`timescale 1ns/1ps
`include "clm_consts.svh"

module clm_exec (
    input  wire logic          clk_sys,
    input  wire logic          reset,
    input  wire logic          start,
    input  clm_pkg::clm_byte_t op_in,
    input  clm_pkg::clm_byte_t b1_in,
    input  clm_pkg::clm_byte_t b2_in,
    input  clm_pkg::clm_byte_t b3_in,
    input  clm_pkg::clm_byte_t rp_base,
    input  clm_pkg::clm_word_t ip_in,
    input  clm_pkg::clm_byte_t flags_in,
    input  clm_pkg::clm_byte_t rf_rdata,
    input  clm_pkg::clm_byte_t mem_rdata,
    input  wire logic [1:0]    sw_addr,
    input  clm_pkg::clm_byte_t sw_wdata,
    input  wire logic          sw_we,
    input  wire logic          sw_re,
    output logic               busy_reg,
    output logic               done_reg,
    output clm_pkg::clm_byte_t rf_raddr_reg,
    output logic               rf_re_reg,
    output clm_pkg::clm_byte_t rf_waddr_reg,
    output clm_pkg::clm_byte_t rf_wdata_reg,
    output logic               rf_we_reg,
    output clm_pkg::clm_word_t mem_addr_reg,
    output clm_pkg::clm_byte_t mem_wdata_reg,
    output logic               mem_re_reg,
    output logic               mem_we_reg,
    output logic               mem_data_sel_reg,
    output clm_pkg::clm_byte_t flags_out_reg,
    output logic               flags_we_reg,
    output clm_pkg::clm_word_t pc_out_reg,
    output logic               pc_we_reg,
    output clm_pkg::clm_word_t ip_out_reg,
    output logic               ip_we_reg,
    output clm_pkg::clm_byte_t sw_rdata_reg
);
    import clm_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    clm_state_t state_reg;          // sequencer
    clm_byte_t  op_reg;             // latched opcode
    clm_byte_t  b1_reg;             // latched operand bytes
    clm_byte_t  b2_reg;
    clm_byte_t  b3_reg;
    clm_word_t  ip_reg;             // latched instruction pointer
    logic [4:0] cnt_reg;            // cycles left
    logic [1:0] k_reg;              // reads issued
    clm_byte_t  t_reg [0:2];        // captured read bytes
    logic       halt_reg;           // refuses new starts
    logic       illegal_reg;        // sticky unknown opcode
    clm_byte_t  lastop_reg;         // last accepted opcode

    // ----------------------------------------
    // decode, from inputs while idle else latched
    // ----------------------------------------
    logic       idle;
    clm_byte_t  cop, cb1, cb2, cb3;
    clm_word_t  cip;
    logic       is_or, is_mul, is_word, is_ldi, is_next, is_nop, legal;
    logic       or_nib, ind, imm, two_wr, go, issue;
    logic [1:0] nrd;
    logic [4:0] cyc;
    logic [3:0] wr_hi;
    clm_byte_t  dsta, srca, pair, rsrc, a0, a1, a2, addr_k, rdat;
    clm_byte_t  srcv, res_or, word_hi, word_lo, w0a, w0d, w1a, w1d, flg_new;
    clm_word_t  prod, inc, mem_rd_addr;

    assign idle    = (state_reg == ST_IDLE);
    assign cop     = idle ? op_in : op_reg;
    assign cb1     = idle ? b1_in : b1_reg;
    assign cb2     = idle ? b2_in : b2_reg;
    assign cb3     = idle ? b3_in : b3_reg;
    assign cip     = idle ? ip_in : ip_reg;
    assign is_or   = cop inside {`CLM_OP_OR_WW, `CLM_OP_OR_WI, `CLM_OP_OR_GG,
                                 `CLM_OP_OR_GI, `CLM_OP_OR_IMM};
    assign is_mul  = cop inside {`CLM_OP_MUL_R, `CLM_OP_MUL_IND, `CLM_OP_MUL_IMM};
    assign is_word = cop inside {`CLM_OP_WORD_PAIR, `CLM_OP_WORD_IND, `CLM_OP_WORD_IMM};
    assign is_ldi  = (cop == `CLM_OP_LDI);
    assign is_next = (cop == `CLM_OP_NEXT);
    assign is_nop  = (cop == `CLM_OP_NOP);
    assign legal   = is_or | is_mul | is_word | is_ldi | is_next | is_nop;
    assign or_nib  = cop inside {`CLM_OP_OR_WW, `CLM_OP_OR_WI};
    assign ind     = cop inside {`CLM_OP_OR_WI, `CLM_OP_OR_GI, `CLM_OP_MUL_IND};
    assign imm     = cop inside {`CLM_OP_OR_IMM, `CLM_OP_MUL_IMM};
    assign two_wr  = is_mul | is_word | is_ldi;
    assign go      = start & idle & ~halt_reg & legal;

    // reads needed per form
    assign nrd = (is_or | is_mul) ? (imm ? 2'h1 : (ind ? 2'h3 : 2'h2)) :
                 (cop == `CLM_OP_WORD_PAIR) ? 2'h2 :
                 (cop == `CLM_OP_WORD_IND) ? 2'h3 :
                 (is_ldi | is_next) ? (is_ldi ? 2'h3 : 2'h2) : 2'h0;
    // cycle budget per form
    assign cyc = is_ldi  ? `CLM_CYC_LDI :
                 is_word ? `CLM_CYC_WORD :
                 is_mul  ? `CLM_CYC_MUL :
                 is_next ? `CLM_CYC_NEXT :
                 (cop == `CLM_OP_OR_WW) ? `CLM_CYC_OR_WW :
                 is_or   ? `CLM_CYC_OR : `CLM_CYC_NOP;

    // operand addresses; working registers sit in the rp_base bank
    assign wr_hi = rp_base[7:4];
    assign dsta  = or_nib ? {wr_hi, cb1[7:4]} :
                   (cop inside {`CLM_OP_OR_IMM, `CLM_OP_WORD_IMM}) ? cb1 :
                   is_mul ? {cb2[7:1], 1'b0} : cb2;
    assign srca  = or_nib ? {wr_hi, cb1[3:0]} : cb1;
    assign pair  = {wr_hi, cb1[3:1], 1'b0};
    assign rsrc  = {wr_hi, cb1[7:4]};
    assign rdat  = is_next ? mem_rdata : rf_rdata;
    assign a0    = is_ldi ? pair : (is_word ? cb1 : dsta);
    assign a1    = is_ldi ? (pair | 8'h01) :
                   (cop == `CLM_OP_WORD_IND) ? rdat :
                   (cop == `CLM_OP_WORD_PAIR) ? cb1 + 8'h01 : srca;
    assign a2    = is_ldi ? rsrc :
                   (cop == `CLM_OP_WORD_IND) ? t_reg[0] + 8'h01 : rdat;
    assign addr_k = (k_reg == 2'h0) ? a0 : ((k_reg == 2'h1) ? a1 : a2);
    assign mem_rd_addr = cip + {14'h0000, k_reg};
    assign issue = (go & (nrd != 2'h0)) | ((state_reg == ST_READ) & (k_reg != nrd));

    // results
    assign srcv   = imm ? ((cop == `CLM_OP_OR_IMM) ? cb2 : cb1) :
                    (ind ? t_reg[2] : t_reg[1]);
    assign res_or = t_reg[0] | srcv;
    assign prod   = {8'h00, t_reg[0]} * {8'h00, srcv};
    assign inc    = {t_reg[0], t_reg[1]} + 16'h0001;
    assign word_hi = (cop == `CLM_OP_WORD_IMM) ? cb2 :
                     ((cop == `CLM_OP_WORD_IND) ? t_reg[1] : t_reg[0]);
    assign word_lo = (cop == `CLM_OP_WORD_IMM) ? cb3 :
                     ((cop == `CLM_OP_WORD_IND) ? t_reg[2] : t_reg[1]);
    assign w0a    = is_ldi ? pair : dsta;
    assign w0d    = is_or ? res_or : is_mul ? prod[15:8] :
                    is_word ? word_hi : inc[15:8];
    assign w1a    = w0a + 8'h01;
    assign w1d    = is_mul ? prod[7:0] : (is_word ? word_lo : inc[7:0]);

    // flag update for or and multiply only
    always_comb begin
        flg_new = flags_in;
        flg_new[`CLM_FLG_V] = 1'b0;
        if (is_mul) begin
            flg_new[`CLM_FLG_C] = |prod[15:8];
            flg_new[`CLM_FLG_Z] = (prod == 16'h0000);
            flg_new[`CLM_FLG_S] = prod[15];
        end else begin
            flg_new[`CLM_FLG_Z] = (res_or == 8'h00);
            flg_new[`CLM_FLG_S] = res_or[7];
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // walks reads, writes, then idles out the cycle budget
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            op_reg    <= 8'h00;
            b1_reg    <= 8'h00;
            b2_reg    <= 8'h00;
            b3_reg    <= 8'h00;
            ip_reg    <= 16'h0000;
            cnt_reg   <= 5'h00;
            k_reg     <= 2'h0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            for (int i = 0; i < 3; i++) t_reg[i] <= 8'h00;
        end else begin
            done_reg <= 1'b0;
            if (!idle) cnt_reg <= cnt_reg - 5'h01;
            unique case (state_reg)
                ST_IDLE: if (go) begin
                    op_reg   <= op_in;
                    b1_reg   <= b1_in;
                    b2_reg   <= b2_in;
                    b3_reg   <= b3_in;
                    ip_reg   <= ip_in;
                    cnt_reg  <= cyc;
                    busy_reg <= 1'b1;
                    if (nrd != 2'h0) begin
                        k_reg     <= 2'h1;
                        state_reg <= ST_READ;
                    end else begin
                        state_reg <= is_nop ? ST_WAIT : ST_WR0;
                    end
                end
                ST_READ: begin
                    t_reg[k_reg - 2'h1] <= rdat;
                    if (k_reg == nrd) state_reg <= ST_WR0;
                    else k_reg <= k_reg + 2'h1;
                end
                ST_WR0: state_reg <= two_wr ? ST_WR1 : ST_WAIT;
                ST_WR1: state_reg <= is_ldi ? ST_WRM : ST_WAIT;
                ST_WRM: state_reg <= ST_WAIT;
                ST_WAIT: ;
            endcase
            if (!idle && cnt_reg == 5'h01) begin
                state_reg <= ST_IDLE;
                k_reg     <= 2'h0;
                busy_reg  <= 1'b0;
                done_reg  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // register file port
    // ----------------------------------------
    // one read or write per cycle, write order high then low
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rf_re_reg    <= 1'b0;
            rf_raddr_reg <= 8'h00;
            rf_we_reg    <= 1'b0;
            rf_waddr_reg <= 8'h00;
            rf_wdata_reg <= 8'h00;
        end else begin
            rf_re_reg <= issue & ~is_next;
            if (issue) rf_raddr_reg <= addr_k;
            rf_we_reg <= ((state_reg == ST_WR0) & ~is_next) | (state_reg == ST_WR1);
            if (state_reg == ST_WR0) begin
                rf_waddr_reg <= w0a;
                rf_wdata_reg <= w0d;
            end else if (state_reg == ST_WR1) begin
                rf_waddr_reg <= w1a;
                rf_wdata_reg <= w1d;
            end
        end
    end

    // ----------------------------------------
    // memory port
    // ----------------------------------------
    // program reads for next, store to program or data space
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_re_reg       <= 1'b0;
            mem_we_reg       <= 1'b0;
            mem_addr_reg     <= 16'h0000;
            mem_wdata_reg    <= 8'h00;
            mem_data_sel_reg <= 1'b0;
        end else begin
            mem_re_reg <= issue & is_next;
            mem_we_reg <= (state_reg == ST_WRM);
            if (issue && is_next) begin
                mem_addr_reg     <= mem_rd_addr;
                mem_data_sel_reg <= 1'b0;
            end else if (state_reg == ST_WRM) begin
                mem_addr_reg     <= inc;
                mem_wdata_reg    <= t_reg[2];
                mem_data_sel_reg <= b1_reg[0];
            end
        end
    end

    // ----------------------------------------
    // flags, pc and ip
    // ----------------------------------------
    // only or and multiply write flags
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flags_we_reg  <= 1'b0;
            flags_out_reg <= 8'h00;
            pc_we_reg     <= 1'b0;
            ip_we_reg     <= 1'b0;
            pc_out_reg    <= 16'h0000;
            ip_out_reg    <= 16'h0000;
        end else begin
            flags_we_reg <= (state_reg == ST_WR0) & (is_or | is_mul);
            pc_we_reg    <= (state_reg == ST_WR0) & is_next;
            ip_we_reg    <= (state_reg == ST_WR0) & is_next;
            if (state_reg == ST_WR0) begin
                flags_out_reg <= flg_new;
                pc_out_reg    <= {t_reg[0], t_reg[1]};
                ip_out_reg    <= ip_reg + `CLM_IP_STEP;
            end
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic       ill_set, ill_clr;
    clm_byte_t  sw_mux;
    assign ill_set = start & idle & ~halt_reg & ~legal;
    assign ill_clr = sw_we & (sw_addr == `CLM_SW_STATUS) & sw_wdata[`CLM_ST_ILL];
    assign sw_mux  = (sw_addr == `CLM_SW_CTRL)   ? {7'h00, halt_reg} :
                     (sw_addr == `CLM_SW_STATUS) ? {6'h00, illegal_reg, busy_reg} :
                     (sw_addr == `CLM_SW_LASTOP) ? lastop_reg : 8'h00;

    // halt steers start acceptance; status shows busy and error
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            halt_reg     <= 1'b0;
            illegal_reg  <= 1'b0;
            lastop_reg   <= 8'h00;
            sw_rdata_reg <= 8'h00;
        end else begin
            if (sw_we && sw_addr == `CLM_SW_CTRL) halt_reg <= sw_wdata[`CLM_CTRL_HALT];
            // a new error in the clearing cycle wins
            illegal_reg  <= ill_set | (illegal_reg & ~ill_clr);
            if (go) lastop_reg <= op_in;
            sw_rdata_reg <= sw_re ? sw_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb_a @(posedge clk_sys); endclocking
    default disable iff (reset);

    nop_time_a: assert property (go && is_nop |-> ##5 done_reg)
        else $error("nop not done in 4 cycles");
    nop_quiet_a: assert property (go && is_nop |=>
        (!rf_we_reg && !mem_we_reg && !flags_we_reg && !pc_we_reg)[*4])
        else $error("nop changed state");
    ldi_time_a: assert property (go && is_ldi |-> ##15 done_reg)
        else $error("pre-increment store not done in 14 cycles");
    ldi_carry_a: assert property (mem_we_reg |->
        mem_addr_reg == {$past(rf_wdata_reg, 2), $past(rf_wdata_reg)})
        else $error("store address differs from written pair");
    ldi_route_a: assert property (mem_we_reg |->
        mem_data_sel_reg == $past(b1_reg[0]))
        else $error("store routed to wrong memory");
    word_time_a: assert property (go && is_word |-> ##9 done_reg)
        else $error("word load not done in 8 cycles");
    mul_time_a: assert property (go && is_mul |-> ##23 done_reg)
        else $error("multiply not done in 22 cycles");
    mul_flags_a: assert property (flags_we_reg && is_mul |->
        flags_out_reg[`CLM_FLG_C] == (rf_wdata_reg != 8'h00) &&
        flags_out_reg[`CLM_FLG_S] == rf_wdata_reg[7] && !flags_out_reg[`CLM_FLG_V])
        else $error("multiply flags wrong");
    or_flags_a: assert property (flags_we_reg && is_or |->
        flags_out_reg[`CLM_FLG_Z] == (rf_wdata_reg == 8'h00) &&
        flags_out_reg[`CLM_FLG_C] == $past(flags_in[`CLM_FLG_C]) &&
        !flags_out_reg[`CLM_FLG_V])
        else $error("or flags wrong");
    flag_keep_a: assert property (flags_we_reg |-> is_or || is_mul)
        else $error("flags written by non-flag instruction");
    next_time_a: assert property (go && is_next |-> ##11 done_reg && $past(pc_we_reg, 7))
        else $error("next timing wrong");

endmodule : clm_exec

// *** rtl/clm_pkg.sv ***
/*
 * types of the execution unit.
 * assumes: clm_consts.svh beside it.
 */
package clm_pkg;
    typedef logic [7:0]  clm_byte_t;   // register file byte
    typedef logic [15:0] clm_word_t;   // memory address / word
    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_WR0, ST_WR1, ST_WRM, ST_WAIT
    } clm_state_t;
endpackage : clm_pkg

// *** verif/clm_mem_model.sv ***
/*
 * far side of the execution unit: register file, program memory,
 * external data memory, flag register, pc and ip.
 * assumes: the unit reads combinationally, writes land on clk_sys.
 */
`timescale 1ns/1ps
module clm_mem_model (
    input  wire logic          clk_sys,
    input  clm_pkg::clm_byte_t rf_raddr_reg,
    input  wire logic          rf_re_reg,
    input  clm_pkg::clm_byte_t rf_waddr_reg,
    input  clm_pkg::clm_byte_t rf_wdata_reg,
    input  wire logic          rf_we_reg,
    input  clm_pkg::clm_word_t mem_addr_reg,
    input  clm_pkg::clm_byte_t mem_wdata_reg,
    input  wire logic          mem_re_reg,
    input  wire logic          mem_we_reg,
    input  wire logic          mem_data_sel_reg,
    input  clm_pkg::clm_byte_t flags_out_reg,
    input  wire logic          flags_we_reg,
    input  clm_pkg::clm_word_t pc_out_reg,
    input  wire logic          pc_we_reg,
    input  clm_pkg::clm_word_t ip_out_reg,
    input  wire logic          ip_we_reg,
    output clm_pkg::clm_byte_t rf_rdata,
    output clm_pkg::clm_byte_t mem_rdata,
    output clm_pkg::clm_byte_t flags_in,
    output clm_pkg::clm_word_t ip_in
);
    import clm_pkg::*;
    clm_byte_t rf [256];     // register file
    clm_byte_t pm [65536];   // program memory
    clm_byte_t dm [65536];   // external data memory, full 64 kbyte
    clm_byte_t flg_reg;      // flag register
    clm_word_t ip_reg;       // instruction pointer
    clm_word_t pc_reg;       // program counter
    clm_byte_t rf_cell;
    clm_byte_t mem_cell;
    assign rf_cell  = rf[rf_raddr_reg];
    assign mem_cell = mem_data_sel_reg ? dm[mem_addr_reg] : pm[mem_addr_reg];
    // released read lines show the inverse
    assign rf_rdata  = rf_re_reg ? rf_cell : ~rf_cell;
    assign mem_rdata = mem_re_reg ? mem_cell : ~mem_cell;
    assign flags_in  = flg_reg;
    assign ip_in     = ip_reg;
    // -------------------------------
    // writes from the unit
    // -------------------------------
    always @(posedge clk_sys) begin
        if (rf_we_reg) rf[rf_waddr_reg] <= rf_wdata_reg;
        if (mem_we_reg && mem_data_sel_reg) dm[mem_addr_reg] <= mem_wdata_reg;
        if (mem_we_reg && !mem_data_sel_reg) pm[mem_addr_reg] <= mem_wdata_reg;
        if (flags_we_reg) flg_reg <= flags_out_reg;
        if (pc_we_reg) pc_reg <= pc_out_reg;
        if (ip_we_reg) ip_reg <= ip_out_reg;
    end
endmodule : clm_mem_model

// *** verif/test_cpu_load_unsigned_multiply_or_exec.sv ***
/*
 * self-checking bench of the execution unit with its memory model.
 * assumes: clm_pkg and clm_mem_model compiled before it.
 */
`timescale 1ns/1ps
module test_cpu_load_unsigned_multiply_or_exec;
    import clm_pkg::*;
    logic       clk_sys, reset, start, sw_we, sw_re;
    logic [1:0] sw_addr;
    clm_byte_t  op_in, b1_in, b2_in, b3_in, rp_base, sw_wdata;
    clm_byte_t  flags_in, rf_rdata, mem_rdata;
    clm_word_t  ip_in, mem_addr_reg, pc_out_reg, ip_out_reg;
    logic       busy_reg, done_reg, rf_re_reg, rf_we_reg, mem_re_reg, mem_we_reg;
    logic       mem_data_sel_reg, flags_we_reg, pc_we_reg, ip_we_reg;
    clm_byte_t  rf_raddr_reg, rf_waddr_reg, rf_wdata_reg, mem_wdata_reg;
    clm_byte_t  flags_out_reg, sw_rdata_reg;
    int         fail_count, compares, cycles, writes, base;

    clm_exec dut_u (.clk_sys, .reset, .start, .op_in, .b1_in, .b2_in, .b3_in,
        .rp_base, .ip_in, .flags_in, .rf_rdata, .mem_rdata, .sw_addr, .sw_wdata,
        .sw_we, .sw_re, .busy_reg, .done_reg, .rf_raddr_reg, .rf_re_reg,
        .rf_waddr_reg, .rf_wdata_reg, .rf_we_reg, .mem_addr_reg, .mem_wdata_reg,
        .mem_re_reg, .mem_we_reg, .mem_data_sel_reg, .flags_out_reg, .flags_we_reg,
        .pc_out_reg, .pc_we_reg, .ip_out_reg, .ip_we_reg, .sw_rdata_reg);
    clm_mem_model part_u (.clk_sys, .rf_raddr_reg, .rf_re_reg, .rf_waddr_reg,
        .rf_wdata_reg, .rf_we_reg, .mem_addr_reg, .mem_wdata_reg, .mem_re_reg,
        .mem_we_reg, .mem_data_sel_reg, .flags_out_reg, .flags_we_reg, .pc_out_reg,
        .pc_we_reg, .ip_out_reg, .ip_we_reg, .rf_rdata, .mem_rdata, .flags_in, .ip_in);

    // -------------------------------
    // clock, write counter, hang guard
    // -------------------------------
    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (rf_we_reg | mem_we_reg | pc_we_reg | ip_we_reg | flags_we_reg) writes++;
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            conclude();
        end
    end

    // -------------------------------
    // tasks
    // -------------------------------
    task automatic conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input clm_word_t g, input clm_word_t e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic sw_wr(input logic [1:0] a, input clm_byte_t d);
        @(posedge clk_sys);
        sw_we    <= 1'b1;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge clk_sys);
        sw_we    <= 1'b0;
    endtask : sw_wr
    task automatic sw_rd(input logic [1:0] a, input clm_byte_t e);
        @(posedge clk_sys);
        sw_re   <= 1'b1;
        sw_addr <= a;
        @(posedge clk_sys);
        sw_re   <= 1'b0;
        #1 chk(sw_rdata_reg, e);
    endtask : sw_rd
    // one start pulse, returns just after the take edge
    task automatic kick(input clm_byte_t op, b1, b2, b3);
        @(posedge clk_sys);
        start <= 1'b1;
        op_in <= op;
        b1_in <= b1;
        b2_in <= b2;
        b3_in <= b3;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
    endtask : kick
    // runs one instruction and checks its length in edges
    task automatic run_op(input clm_byte_t op, b1, b2, b3, input clm_word_t n);
        int k;
        kick(op, b1, b2, b3);
        chk(busy_reg, 1'b1);
        k = 0;
        while (done_reg !== 1'b1 && k < 40) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk(clm_word_t'(k), n);
        @(posedge clk_sys);
        #1 chk(done_reg, 1'b0);
    endtask : run_op
    // multiply or logical or: places operands, runs, checks result and flags
    task automatic alu(input clm_byte_t op, b1, b2, d, s, f0);
        clm_byte_t da, sa, ef, r;
        clm_word_t pr;
        logic      m, w;
        w  = (op == 8'h42 || op == 8'h43);
        m  = (op[7:4] == 4'h8);
        da = w ? {rp_base[7:4], b1[7:4]} : (op == 8'h46) ? b1 : b2;
        sa = w ? {rp_base[7:4], b1[3:0]} : b1;
        if (m) da[0] = 1'b0;
        part_u.flg_reg = f0;
        part_u.rf[da]  = d;
        if (op[0]) part_u.rf[sa] = 8'h70;
        if (op[0]) part_u.rf[8'h70] = s;
        else if (op != 8'h46 && op != 8'h86) part_u.rf[sa] = s;
        pr = d * s;
        r  = d | s;
        ef = m ? {pr > 16'h00ff, pr == 16'h0000, pr[15], 1'b0, f0[3:0]}
               : {f0[7], r == 8'h00, r[7], 1'b0, f0[3:0]};
        run_op(op, b1, b2, 8'h00, m ? 16'd22 : (op == 8'h42) ? 16'd4 : 16'd6);
        if (m) chk({part_u.rf[da], part_u.rf[da + 8'h01]}, pr);
        else chk(part_u.rf[da], r);
        chk(part_u.flg_reg, ef);
        if (op != 8'h46 && op != 8'h86) chk(part_u.rf[op[0] ? 8'h70 : sa], s);
    endtask : alu

    // -------------------------------
    // main sequence
    // -------------------------------
    initial begin
        reset = 1'b1;
        {start, sw_we, sw_re, sw_addr, sw_wdata} = '0;
        {op_in, b1_in, b2_in, b3_in} = '0;
        rp_base = 8'h10;
        repeat (2) @(posedge clk_sys);
        chk({done_reg, busy_reg, rf_we_reg, mem_we_reg, flags_we_reg}, 16'h0000);
        reset <= 1'b0;
        sw_rd(2'h1, 8'h00);
        $display("test reset done");
        // pre-increment store, carry into high byte, both memories
        part_u.rf[8'h10] = 8'h7f;
        part_u.rf[8'h16] = 8'h21;
        part_u.rf[8'h17] = 8'hff;
        part_u.dm[16'h2200] = 8'h5a;
        part_u.pm[16'hff00] = 8'h5a;
        part_u.flg_reg = 8'ha5;
        run_op(8'hf3, 8'h06, 8'h00, 8'h00, 16'd14);
        chk({part_u.rf[8'h16], part_u.rf[8'h17]}, 16'h2200);
        chk(part_u.pm[16'h2200], 8'h7f);
        chk(part_u.dm[16'h2200], 8'h5a);
        {part_u.rf[8'h16], part_u.rf[8'h17]} = 16'hfeff;
        run_op(8'hf3, 8'h07, 8'h00, 8'h00, 16'd14);
        chk(part_u.dm[16'hff00], 8'h7f);
        chk(part_u.pm[16'hff00], 8'h5a);
        chk(part_u.rf[8'h10], 8'h7f);
        $display("test load_mem done");
        // word loads: pair, indirect, immediate
        part_u.rf[8'h24] = 8'h06;
        part_u.rf[8'h25] = 8'h1c;
        part_u.rf[8'h30] = 8'h2c;
        part_u.rf[8'h2c] = 8'h03;
        part_u.rf[8'h2d] = 8'h0f;
        run_op(8'hc4, 8'h24, 8'h26, 8'h00, 16'd8);
        run_op(8'hc5, 8'h30, 8'h28, 8'h00, 16'd8);
        run_op(8'hc6, 8'h2a, 8'h12, 8'h34, 16'd8);
        chk({part_u.rf[8'h26], part_u.rf[8'h27]}, 16'h061c);
        chk({part_u.rf[8'h24], part_u.rf[8'h25]}, 16'h061c);
        chk({part_u.rf[8'h28], part_u.rf[8'h29]}, 16'h030f);
        chk({part_u.rf[8'h2a], part_u.rf[8'h2b]}, 16'h1234);
        chk(part_u.flg_reg, 8'ha5);
        $display("test load_word done");
        // multiply: carry boundary, odd destination, zero
        alu(8'h84, 8'h42, 8'h40, 8'h20, 8'h09, 8'h5f);
        alu(8'h85, 8'h46, 8'h48, 8'h01, 8'hff, 8'ha0);
        alu(8'h86, 8'hff, 8'h4a, 8'hff, 8'hff, 8'h00);
        alu(8'h86, 8'h00, 8'h4d, 8'h37, 8'h00, 8'h10);
        $display("test multiply done");
        // logical or in every source form
        alu(8'h42, 8'h01, 8'h00, 8'h15, 8'h2a, 8'h8f);
        alu(8'h43, 8'h23, 8'h00, 8'h00, 8'h00, 8'h00);
        alu(8'h44, 8'h52, 8'h54, 8'h08, 8'h80, 8'h10);
        alu(8'h45, 8'h56, 8'h58, 8'h01, 8'h36, 8'h80);
        alu(8'h46, 8'h5a, 8'h02, 8'h08, 8'h02, 8'h7f);
        $display("test or done");
        // threaded next and no-operation
        part_u.ip_reg = 16'h3000;
        part_u.pm[16'h3000] = 8'h12;
        part_u.pm[16'h3001] = 8'h34;
        part_u.flg_reg = 8'h3c;
        run_op(8'h0f, 8'h00, 8'h00, 8'h00, 16'd10);
        chk(part_u.pc_reg, 16'h1234);
        chk(part_u.ip_reg, 16'h3002);
        base = writes;
        run_op(8'hff, 8'h00, 8'h00, 8'h00, 16'd4);
        chk(clm_word_t'(writes - base), 16'h0000);
        chk(part_u.flg_reg, 8'h3c);
        $display("test next_nop done");
        // software port: last opcode, halt, illegal flag, unmapped offset
        sw_rd(2'h2, 8'hff);
        sw_wr(2'h0, 8'h01);
        kick(8'hff, 8'h00, 8'h00, 8'h00);
        chk(busy_reg, 1'b0);
        sw_rd(2'h0, 8'h01);
        sw_wr(2'h0, 8'h00);
        kick(8'h00, 8'h00, 8'h00, 8'h00);
        chk(busy_reg, 1'b0);
        sw_rd(2'h1, 8'h02);
        sw_wr(2'h1, 8'h02);
        sw_rd(2'h1, 8'h00);
        sw_rd(2'h3, 8'h00);
        $display("test sw_port done");
        conclude();
    end
endmodule : test_cpu_load_unsigned_multiply_or_exec
